// >>> hw/rsc_timer.sv
// Down counter timing the internal initialization phase
module rsc_timer
    import rsc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    rsc_tmr_if.tmr t
);
    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [31:0] count;
        logic busy;
        logic done;
    } rsc_tmr_state_t;

    rsc_tmr_state_t r;
    rsc_tmr_state_t next_r;

    // Load on start, count down, done holds until next start
    always_comb
    begin
        next_r = r;
        if (t.start)
        begin
            next_r.count = t.load;
            next_r.busy = 1'b1;
            next_r.done = 1'b0;
        end
        else if (r.busy)
        begin
            // A zero load still takes one cycle
            if (r.count <= 32'h00000001)
            begin
                next_r.busy = 1'b0;
                next_r.done = 1'b1;
            end
            else
            begin
                next_r.count = r.count - 32'h00000001;
            end
        end
    end

    // State register
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            r <= '0;
        else
            r <= next_r;
    end

    assign t.done = r.done;
endmodule : rsc_timer

// >>> hw/rsc_top.sv
// Reset source controller: source merge, init timing, cause flags, APB registers
//
// Summary of operation
// [R1] Debug reset spares debug port, override, brown-out config
// [R2] Debug reset comes only from debug port
// [R3] Fuse registers reload after every reset release
// [R4] Hold reset while any source is active
// [R5] Then run a 250 us initialization phase
// [R6] Startup fuse lengthens the initialization phase
// [R7] Boot CRC adds 500 us per kilobyte
// [R8] Works in active and all sleep modes
// [R9] Software reset needs unlock key within four cycles
// [R10] Locked writes accepted silently, value unchanged
// [R11] Writing one clears a cause flag
// [R12] Power-on clears all flags but its own
// [R13] Cause bits: 5 debug down to 0 power-on
// [R14] Only power-on flag until full boot completes
// [R15] Power-on flag cleared only by software
// [R16] Writing go bit starts software reset immediately
// [R17] Go bit never stored, reads zero
// [R18] Sw, pin, watchdog spare debug, override, brown-out
// [R19] Pin source only counts when fuse enables it
// [R20] Power-on resets all, brown-out spares its config
//
// Design decision made here: the APB slave port.
module rsc_top
    import rsc_pkg::*;
#(
    parameter int INIT_CYCLES_P = INIT_CYCLES,
    parameter logic [7:0] IO_UNLOCK_KEY = IO_UNLOCK_KEY_DEFAULT
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic por_active,
    input wire logic bor_active,
    input wire logic reset_pin_n,
    input wire logic pin_reset_fuse,
    input wire logic wdt_reset_req,
    input wire logic dbg_reset_req,
    input wire logic [2:0] startup_delay_fuse,
    input wire logic [1:0] boot_crc_source_select,
    input wire logic [7:0] crc_check_kbytes,
    output logic core_reset,
    output logic timer_override_reset,
    output logic bod_config_reset,
    output logic debug_port_reset,
    output logic fuse_reload,
    output logic cpu_run
);
    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        rsc_state_t state;
        logic [5:0] cause;
        logic [5:0] src_q;
        logic boot_ok;
        logic [2:0] unlock_cnt;
        logic sw_req;
        logic start;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic core_reset;
        logic tmr_reset;
        logic bod_reset;
        logic dbg_reset;
        logic fuse_reload;
        logic cpu_run;
    } rsc_top_state_t;

    rsc_top_state_t r;
    rsc_top_state_t next_r;
    rsc_tmr_if tif ();

    // Word index decode, misaligned or out of range gives an unmapped code
    function automatic logic [9:0] reg_index(input logic [11:0] a);
        reg_index = (a[1:0] == 2'h0) ? a[11:2] : 10'h3FF;
    endfunction : reg_index

    function automatic logic mapped(input logic [9:0] idx);
        mapped = (idx <= REG_STATUS_IDX);
    endfunction : mapped

    // ****************************************
    // Source gathering
    // ****************************************
    logic [5:0] src;
    logic any_src;
    logic [5:0] src_rise;
    logic [31:0] init_load;
    logic [31:0] crc_load;
    logic [9:0] idx;
    logic wr_acc;
    logic rd_setup;

    // [R2] Debug request pin only
    // [R19] Pin gated by fuse
    // [R4] Level sources held
    always_comb
    begin
        src = '0;
        src[FLAG_POR] = por_active;
        src[FLAG_BOR] = bor_active;
        src[FLAG_PIN] = pin_reset_fuse & ~reset_pin_n;
        src[FLAG_WDT] = wdt_reset_req;
        src[FLAG_SW] = r.sw_req;
        src[FLAG_DBG] = dbg_reset_req;
        any_src = |src;
        src_rise = src & ~r.src_q;
    end

    // [R5] Base init time
    // [R6] Startup fuse extension
    // [R7] CRC time per kilobyte
    always_comb
    begin
        crc_load = 32'(crc_check_kbytes) * 32'(CRC_CYCLES_PER_KB);
        if (boot_crc_source_select == 2'h0)
            crc_load = '0;
        init_load = 32'(INIT_CYCLES_P) + 32'(startup_delay_fuse) * 32'(SUT_STEP_CYCLES) + crc_load;
    end

    // Bus phase qualifiers
    assign idx = reg_index(paddr);
    assign wr_acc = psel & penable & r.pready & pwrite;
    assign rd_setup = psel & ~penable;

    // ****************************************
    // Next state
    // ****************************************
    // [R8] No sleep or clock gate input; always running
    always_comb
    begin
        next_r = r;
        next_r.src_q = src;
        next_r.sw_req = 1'b0;
        next_r.start = 1'b0;
        next_r.fuse_reload = 1'b0;

        // Unlock window counts down each cycle
        if (r.unlock_cnt != 3'h0)
            next_r.unlock_cnt = r.unlock_cnt - 3'h1;

        // Register writes take effect at the access edge
        if (wr_acc)
        begin
            if (idx == REG_UNLOCK_IDX)
            begin
                if (pwdata[7:0] == IO_UNLOCK_KEY)
                    next_r.unlock_cnt = UNLOCK_WINDOW_CYCLES;
            end
            else if (idx == REG_SWRT_IDX)
            begin
                // [R9] Needs open window
                // [R10] Locked write dropped
                // [R16] Go bit fires
                if ((r.unlock_cnt != 3'h0) && pwdata[SWRT_GO_BIT])
                    next_r.sw_req = 1'b1;
                if (r.unlock_cnt != 3'h0)
                    next_r.unlock_cnt = 3'h0;
            end
        end

        // Cause flags, a new event wins over a clear in the same cycle
        // [R11] Write one clears
        if (wr_acc && (idx == REG_CAUSE_IDX))
            next_r.cause = r.cause & ~pwdata[5:0];
        // [R13] Flag per source
        // [R14] Held off until boot done
        if (r.boot_ok)
            next_r.cause = next_r.cause | (src_rise & ~CAUSE_RESET);
        // [R12] Power-on clears others
        // [R15] Power-on flag only set here
        if (por_active)
        begin
            next_r.cause = CAUSE_RESET;
            next_r.boot_ok = 1'b0;
        end

        // Sequencer
        unique case (r.state)
            RSC_HOLD:
            begin
                // [R4] Wait for all sources released
                if (!any_src)
                begin
                    next_r.state = RSC_RELOAD;
                    next_r.start = 1'b1;
                    // [R3] Fuse reload pulse
                    next_r.fuse_reload = 1'b1;
                end
            end
            RSC_RELOAD:
            begin
                next_r.state = RSC_INIT;
            end
            RSC_INIT:
            begin
                // [R5] Leave after timer expiry
                if (tif.done)
                begin
                    next_r.state = RSC_RUN;
                    next_r.boot_ok = ~por_active;
                end
            end
            RSC_RUN:
            begin
            end
        endcase
        // Any source aborts the sequence and restarts it
        if (any_src)
            next_r.state = RSC_HOLD;

        // Core reset and run registered from the next state, other resets from the supply sources
        // [R18] Core reset covers sw, pin, watchdog
        // [R1] Debug reset core only
        next_r.core_reset = (next_r.state != RSC_RUN);
        next_r.cpu_run = (next_r.state == RSC_RUN);
        // [R20] Brown-out spares its config
        next_r.tmr_reset = por_active | bor_active;
        next_r.dbg_reset = por_active | bor_active;
        next_r.bod_reset = por_active;

        // Read data and answer prepared in setup so access has no wait
        next_r.pready = rd_setup;
        next_r.pslverr = rd_setup & ~mapped(idx);
        next_r.prdata = '0;
        if (rd_setup && !pwrite)
        begin
            unique case (idx)
                REG_CAUSE_IDX: next_r.prdata[5:0] = r.cause;
                // [R17] Go bit reads zero
                REG_SWRT_IDX: next_r.prdata = '0;
                REG_UNLOCK_IDX: next_r.prdata = '0;
                REG_STATUS_IDX: next_r.prdata[5:0] = {r.boot_ok, r.unlock_cnt, r.state};
                default: next_r.prdata = '0;
            endcase
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    // Power-up state: holding, power-on flag set, every reset asserted
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            r <= '0;
            r.state <= RSC_HOLD;
            r.cause <= CAUSE_RESET;
            r.core_reset <= 1'b1;
            r.tmr_reset <= 1'b1;
            r.bod_reset <= 1'b1;
            r.dbg_reset <= 1'b1;
        end
        else
        begin
            r <= next_r;
        end
    end

    // ****************************************
    // Init timer
    // ****************************************
    assign tif.start = r.start;
    assign tif.load = init_load;

    rsc_timer u_timer (
        .clk (clk),
        .rst (rst),
        .t (tif.tmr)
    );

    // Outputs straight from state flops
    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign core_reset = r.core_reset;
    assign timer_override_reset = r.tmr_reset;
    assign bod_config_reset = r.bod_reset;
    assign debug_port_reset = r.dbg_reset;
    assign fuse_reload = r.fuse_reload;
    assign cpu_run = r.cpu_run;
endmodule : rsc_top

// >>> include/rsc_pkg.sv
// Constants, offsets and state codes of the reset source controller
package rsc_pkg;
    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_HZ = 20_000_000;
    localparam int CLK_PER_US = CLK_HZ / 1_000_000;
    localparam int INIT_TIME_US = 250;
    localparam int CRC_TIME_US_PER_KB = 500;
    localparam int SUT_STEP_TIME_US = 1000;
    localparam int INIT_CYCLES = INIT_TIME_US * CLK_PER_US;
    localparam int CRC_CYCLES_PER_KB = CRC_TIME_US_PER_KB * CLK_PER_US;
    localparam int SUT_STEP_CYCLES = SUT_STEP_TIME_US * CLK_PER_US;
    localparam logic [2:0] UNLOCK_WINDOW_CYCLES = 3'h4;

    // ****************************************
    // Register indices, byte address is four times the index
    // ****************************************
    localparam logic [9:0] REG_CAUSE_IDX = 10'h000;
    localparam logic [9:0] REG_SWRT_IDX = 10'h001;
    localparam logic [9:0] REG_UNLOCK_IDX = 10'h002;
    localparam logic [9:0] REG_STATUS_IDX = 10'h003;

    // ****************************************
    // Fields and reset values
    // ****************************************
    localparam int FLAG_POR = 0;
    localparam int FLAG_BOR = 1;
    localparam int FLAG_PIN = 2;
    localparam int FLAG_WDT = 3;
    localparam int FLAG_SW = 4;
    localparam int FLAG_DBG = 5;
    localparam int SWRT_GO_BIT = 0;
    localparam logic [5:0] CAUSE_RESET = 6'h01;
    localparam logic [7:0] IO_UNLOCK_KEY_DEFAULT = 8'hA5;

    // ****************************************
    // Sequencer states, Gray order hold-reload-init-run
    // ****************************************
    typedef enum logic [1:0] {
        RSC_HOLD = 2'h0,
        RSC_RELOAD = 2'h1,
        RSC_INIT = 2'h3,
        RSC_RUN = 2'h2
    } rsc_state_t;
endpackage : rsc_pkg

// >>> include/rsc_tmr_if.sv
// Start, load and done link between sequencer and init timer
interface rsc_tmr_if;
    logic start;
    logic [31:0] load;
    logic done;
    modport ctl (output start, output load, input done);
    modport tmr (input start, input load, output done);
endinterface : rsc_tmr_if

// >>> verif/reset_source_controller_bench.sv
// Self-checking bench of the reset source controller
module reset_source_controller_bench import rsc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int N = 20;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel, penable, pwrite, pready, pslverr, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic por_active, bor_active, reset_pin_n, wdt_reset_req, dbg_reset_req;
    logic pin_reset_fuse, core_reset, timer_override_reset;
    logic bod_config_reset, debug_port_reset, fuse_reload, cpu_run;
    logic [2:0] startup_delay_fuse;
    logic [1:0] boot_crc_source_select;
    logic [7:0] crc_check_kbytes;
    int err_total = 0;
    int check_count = 0;
    int cyc = 0;
    int exp_f, n, m;
    integer seed = 32'h9F2BD2C0;
    int fb[4] = '{FLAG_BOR, FLAG_PIN, FLAG_WDT, FLAG_DBG};
    rsc_top #(.INIT_CYCLES_P(N)) DUT (.clk, .rst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .por_active, .bor_active, .reset_pin_n,
        .pin_reset_fuse, .wdt_reset_req, .dbg_reset_req, .startup_delay_fuse,
        .boot_crc_source_select, .crc_check_kbytes, .core_reset, .timer_override_reset,
        .bod_config_reset, .debug_port_reset, .fuse_reload, .cpu_run);
    rsc_partner peer (.clk, .por_active, .bor_active, .reset_pin_n, .wdt_reset_req, .dbg_reset_req);
    initial forever #25 clk = ~clk;
    // ****************
    // Tasks
    // ****************
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    begin
        check_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    end
    endtask : chk
    // One APB transfer, waits on pready
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
    begin
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        // No own limit: only the bench timeout ends a hung wait
        do
        begin
            @(posedge clk);
            k++;
        end
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    end
    endtask : apb
    // Cycles until the core runs
    task settle(output int c);
    begin
        c = 0;
        while (cpu_run !== 1'b1)
        begin
            @(posedge clk);
            c++;
        end
    end
    endtask : settle
    task rc();
    begin
        apb(1'b0, 12'h000, 32'h0);
        chk("cause", rd, exp_f);
    end
    endtask : rc
    task complete_run();
    begin
        $display("Checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    end
    endtask : complete_run
    // Hang guard, far above the longest boot
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            err_total++;
            complete_run();
        end
    end
    // ****************
    // Sequence
    // ****************
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        pin_reset_fuse = 1'b1;
        {startup_delay_fuse, boot_crc_source_select, crc_check_kbytes} = '0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        peer.hit(0, 5);
        settle(n);
        chk("init", n >= N && n <= N + 8, 1);
        exp_f = 1;
        rc();
        for (int i = 0; i < 4; i++)
        begin
            peer.hit(i + 1, 4);
            settle(n);
            exp_f |= 1 << fb[i];
            rc();
        end
        apb(1'b0, 12'h004, 32'h0);
        chk("go", rd, 0);
        // Pin must be ignored with its fuse off
        pin_reset_fuse <= 1'b0;
        peer.hit(2, 5);
        chk("pin off", cpu_run, 1);
        pin_reset_fuse <= 1'b1;
        apb(1'b1, 12'h004, 32'h1);
        repeat (4) @(posedge clk);
        chk("locked", cpu_run, 1);
        apb(1'b1, 12'h008, {24'h0, IO_UNLOCK_KEY_DEFAULT});
        apb(1'b1, 12'h004, 32'h1);
        repeat (3) @(posedge clk);
        chk("swrst", core_reset, 1);
        settle(n);
        exp_f |= 1 << FLAG_SW;
        rc();
        m = $random(seed) & 32'h3F;
        apb(1'b1, 12'h000, m);
        exp_f &= ~m;
        rc();
        apb(1'b0, 12'h010, 32'h0);
        chk("slverr", er, 1);
        peer.hit(0, 3);
        settle(n);
        exp_f = 1;
        rc();
        // Slow boot: one start-up step and one CRC kilobyte
        startup_delay_fuse <= 3'h1;
        boot_crc_source_select <= 2'h1;
        crc_check_kbytes <= 8'h01;
        peer.hit(0, 3);
        settle(n);
        chk("long init", n >= N + 30000 && n <= N + 30008, 1);
        complete_run();
    end
endmodule : reset_source_controller_bench
bind rsc_top rsc_monitor mon (.clk, .rst, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
    .pslverr, .por_active, .bor_active, .reset_pin_n, .pin_reset_fuse, .wdt_reset_req,
    .dbg_reset_req, .core_reset, .timer_override_reset, .bod_config_reset, .debug_port_reset,
    .fuse_reload);

// >>> verif/rsc_monitor.sv
// Port assertions for the reset source controller
module rsc_monitor
(
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic por_active,
    input wire logic bor_active,
    input wire logic reset_pin_n,
    input wire logic pin_reset_fuse,
    input wire logic wdt_reset_req,
    input wire logic dbg_reset_req,
    input wire logic core_reset,
    input wire logic timer_override_reset,
    input wire logic bod_config_reset,
    input wire logic debug_port_reset,
    input wire logic fuse_reload
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // ****************
    // Checks
    // ****************
    hold_on_src_a: assert property ((por_active | bor_active | wdt_reset_req | dbg_reset_req) |=> core_reset)
        else $error("core not held in reset");
    pin_hold_a: assert property (pin_reset_fuse && !reset_pin_n |=> core_reset)
        else $error("pin reset ignored");
    init_hold_a: assert property (fuse_reload |=> core_reset [*8])
        else $error("init phase cut short");
    dbg_spare_a: assert property (dbg_reset_req && !por_active && !bor_active |=> !debug_port_reset)
        else $error("debug port reset by itself");
    bod_spare_a: assert property (bor_active && !por_active |=> !bod_config_reset && debug_port_reset)
        else $error("brownout config not spared");
    upper_zero_a: assert property (pready && !pwrite && paddr == 12'h000 |-> prdata[31:6] == 26'h0)
        else $error("cause upper bits not zero");
    go_zero_a: assert property (pready && !pwrite && paddr == 12'h004 |-> prdata == 32'h0)
        else $error("go bit read nonzero");
    bad_addr_a: assert property (psel && penable && pready && paddr > 12'h00C |-> pslverr)
        else $error("unmapped access not flagged");
    override_spare_a: assert property (wdt_reset_req && !por_active && !bor_active |=> !timer_override_reset)
        else $error("timer override reset by user source");
    // Main scenarios reached
    cover property (fuse_reload);
    cover property (dbg_reset_req ##1 core_reset);
    cover property (pslverr);
endmodule : rsc_monitor

// >>> verif/rsc_partner.sv
// Supply monitors, reset pin, watchdog and debugger model
module rsc_partner
(
    input wire logic clk,
    output logic por_active,
    output logic bor_active,
    output logic reset_pin_n,
    output logic wdt_reset_req,
    output logic dbg_reset_req
);
    timeunit 1ns;
    timeprecision 1ns;
    // Active sources: 0 por, 1 bor, 2 pin, 3 wdt, 4 dbg
    logic [4:0] act = 5'h00;
    assign por_active = act[0];
    assign bor_active = act[1];
    // pin low holds; pulled up when released
    assign reset_pin_n = ~act[2];
    assign wdt_reset_req = act[3];
    assign dbg_reset_req = act[4];
    // Raise one source for len cycles
    task hit(input int s, input int len);
    begin
        @(posedge clk);
        act[s] <= 1'b1;
        repeat (len) @(posedge clk);
        act[s] <= 1'b0;
    end
    endtask : hit
endmodule : rsc_partner
